// *** rtl/seq_consts.svh ***
// constants for the sequence store controller
`ifndef SEQ_CONSTS_SVH
`define SEQ_CONSTS_SVH
`define SEQ_NUM_W    6
`define SEQ_COUNT    40
`define SEQ_IDX_W    6
`define SEQ_MIN      6'h01
`define SEQ_MAX_DEF  6'h28
`define SEQ_MAX_RUN  6'h27
`define FSEL_MIN     6'h00
`define FSEL_RESET   6'h00
`define IDX_LAST     6'h27
`define IDX_ZERO     6'h00
`define IDX_ONE      6'h01
`define BYTES_W      16
`define BYTES_ZERO   16'h0000
`define LEN_W        8
`define PTR_W        16
`define CALL_DEPTH   16
`define DEPTH_W      5
`define DEPTH_ZERO   5'h00
`define DEPTH_ONE    5'h01
`define DEPTH_FULL   5'h10
`define FC_CODE_NONE 8'h00
`define FC_CODE_DOFF 8'h16
`define FC_CODE_PERR 8'h20
`define FC_CODE_CURR 8'h22
`define FC_CODE_PLUG 8'h23
`define FC_CODE_CSUM 8'h30
`define FC_CODE_SER  8'h60
`define FC_CODE_PULS 8'h61
`define FC_CODE_USER 8'h66
`define FC_CODE_CPU  8'h88
`endif

// *** rtl/seq_pkg.sv ***
// types shared by the sequence store controller files
package seq_pkg;
  `include "seq_consts.svh"

  typedef enum logic [3:0] {
    OP_NOP     = 4'h0,
    OP_DEFINE  = 4'h1,
    OP_END_DEF = 4'h2,
    OP_ERASE   = 4'h3,
    OP_DIR     = 4'h4,
    OP_FSEL    = 4'h5,
    OP_JUMP    = 4'h6,
    OP_CALL    = 4'h7,
    OP_OTHER   = 4'h8
  } cmd_op_e;

  typedef enum logic [1:0] {
    EX_JUMP   = 2'h0,
    EX_CALL   = 2'h1,
    EX_RESUME = 2'h2,
    EX_FAULT  = 2'h3
  } exec_kind_e;

  typedef enum logic [3:0] {
    CAUSE_NONE = 4'h0,
    CAUSE_DOFF = 4'h1,
    CAUSE_PERR = 4'h2,
    CAUSE_CURR = 4'h3,
    CAUSE_PLUG = 4'h4,
    CAUSE_CSUM = 4'h5,
    CAUSE_SER  = 4'h6,
    CAUSE_PULS = 4'h7,
    CAUSE_USER = 4'h8,
    CAUSE_CPU  = 4'h9
  } fault_cause_e;

  typedef struct packed {
    logic [`SEQ_NUM_W-1:0] seq;
    logic [`PTR_W-1:0]     ptr;
  } ret_s;

  typedef struct packed {
    cmd_op_e               op;
    logic [`SEQ_NUM_W-1:0] num;
    logic                  immediate;
    logic [`LEN_W-1:0]     len;
    ret_s                  ret;
  } cmd_s;

  typedef struct packed {
    exec_kind_e            kind;
    logic [`SEQ_NUM_W-1:0] seq;
    logic [`PTR_W-1:0]     ptr;
  } exec_s;

  typedef struct packed {
    logic                  none_defined;
    logic                  last;
    logic [`SEQ_NUM_W-1:0] seq;
    logic [`BYTES_W-1:0]   bytes;
  } dir_rec_s;

  typedef struct packed {
    logic [7:0] code;
    logic       panel;
  } fault_rpt_s;
endpackage

// *** rtl/call_return_stack.sv ***
// return-point stack for nested sequence calls
`timescale 1ns/10ps
`include "seq_consts.svh"
module call_return_stack
  import seq_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_ce,
  input  wire logic i_clear,
  input  wire logic i_push,
  input  wire logic i_pop,
  input  wire ret_s i_data,
  output ret_s      o_top,
  output logic      o_empty,
  output logic      o_full
);
  ret_s                mem_r [0:`CALL_DEPTH-1];
  logic [`DEPTH_W-1:0] depth_r;
  logic [`DEPTH_W-1:0] depth_nxt;

  always_comb begin
    depth_nxt = depth_r;
    if (i_clear) begin
      depth_nxt = `DEPTH_ZERO;
    end else if (i_push && !o_full) begin
      depth_nxt = depth_r + `DEPTH_ONE;
    end else if (i_pop && !o_empty) begin
      depth_nxt = depth_r - `DEPTH_ONE;
    end
  end

  // data words need no reset; depth alone says what is valid
  always_ff @(posedge i_clk) begin
    if (i_ce && !i_clear && i_push && !o_full) begin
      mem_r[depth_r[`DEPTH_W-2:0]] <= i_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      depth_r <= `DEPTH_ZERO;
    end else if (i_ce) begin
      depth_r <= depth_nxt;
    end
  end

  assign o_empty = (depth_r == `DEPTH_ZERO);
  assign o_full  = (depth_r == `DEPTH_FULL);
  assign o_top   = o_empty ? '0 : mem_r[4'(depth_r - `DEPTH_ONE)];
endmodule

// *** rtl/fault_code_encoder.sv ***
// maps a fault cause to its two-digit code and panel flag
`timescale 1ns/10ps
`include "seq_consts.svh"
module fault_code_encoder
  import seq_pkg::*;
(
  input  wire logic         i_clk,
  input  wire logic         i_sys_rst,
  input  wire logic         i_ce,
  input  wire fault_cause_e i_cause,
  output fault_rpt_s        o_rpt
);
  fault_rpt_s rpt_r;
  fault_rpt_s rpt_nxt;

  always_comb begin
    rpt_nxt.panel = 1'b1;
    case (i_cause)
      CAUSE_NONE: rpt_nxt.code = `FC_CODE_NONE;
      CAUSE_DOFF: rpt_nxt.code = `FC_CODE_DOFF;
      CAUSE_PERR: rpt_nxt.code = `FC_CODE_PERR;
      CAUSE_CURR: rpt_nxt.code = `FC_CODE_CURR;
      CAUSE_PLUG: rpt_nxt.code = `FC_CODE_PLUG;
      CAUSE_CSUM: rpt_nxt.code = `FC_CODE_CSUM;
      CAUSE_SER: begin
        rpt_nxt.code  = `FC_CODE_SER;
        rpt_nxt.panel = 1'b0;
      end
      CAUSE_PULS: rpt_nxt.code = `FC_CODE_PULS;
      CAUSE_USER: rpt_nxt.code = `FC_CODE_USER;
      CAUSE_CPU:  rpt_nxt.code = `FC_CODE_CPU;
      default:    rpt_nxt.code = `FC_CODE_CPU;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rpt_r <= '{code: `FC_CODE_NONE, panel: 1'b1};
    end else if (i_ce) begin
      rpt_r <= rpt_nxt;
    end
  end

  assign o_rpt = rpt_r;
endmodule

// *** rtl/sequence_store_ctrl.sv ***
// command-level control of stored motion sequences
`timescale 1ns/10ps
`include "seq_consts.svh"
module sequence_store_ctrl
  import seq_pkg::*;
(
  input  wire logic         i_clk,
  input  wire logic         i_sys_rst,
  input  wire logic         i_ce,
  input  wire logic         i_cmd_valid,
  input  wire cmd_s         i_cmd,
  input  wire logic         i_seq_done,
  input  wire logic         i_kill,
  input  wire fault_cause_e i_fault_cause,
  output logic              o_recording,
  output logic [`SEQ_NUM_W-1:0] o_rec_seq,
  output logic              o_dir_valid,
  output dir_rec_s          o_dir_rec,
  output logic              o_fsel_valid,
  output logic [`SEQ_NUM_W-1:0] o_fsel,
  output logic              o_exec_valid,
  output exec_s             o_exec,
  output logic              o_call_overflow,
  output logic              o_cmd_refused,
  output fault_rpt_s        o_fault_rpt
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic in_range(input logic [`SEQ_NUM_W-1:0] n,
                                    input logic [`SEQ_NUM_W-1:0] lo,
                                    input logic [`SEQ_NUM_W-1:0] hi);
    in_range = (n >= lo) && (n <= hi);
  endfunction

  // sequence n lives at table slot n-1
  function automatic logic [`SEQ_IDX_W-1:0] slot(
      input logic [`SEQ_NUM_W-1:0] n);
    slot = n - `SEQ_MIN;
  endfunction

  function automatic logic any_above(input logic [`SEQ_COUNT-1:0] m,
                                     input logic [`SEQ_IDX_W-1:0] i);
    any_above = ((m >> (i + `IDX_ONE)) != '0);
  endfunction

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REC  = 2'b01,
    ST_DIR  = 2'b10
  } st_e;

  ////////////////////////////////////////////////////////////////////////
  // state

  st_e                     state_r, state_nxt;
  logic [`SEQ_NUM_W-1:0]   rec_num_r, rec_num_nxt;
  logic [`SEQ_COUNT-1:0]   defined_r, defined_nxt;
  logic [`BYTES_W-1:0]     bytes_r [0:`SEQ_COUNT-1];
  logic [`BYTES_W-1:0]     bytes_nxt [0:`SEQ_COUNT-1];
  logic [`SEQ_IDX_W-1:0]   dir_idx_r, dir_idx_nxt;
  logic [`SEQ_NUM_W-1:0]   fsel_r, fsel_nxt;
  logic                    fsel_v_r, fsel_v_nxt;
  logic                    fault_prev_r, fault_prev_nxt;
  logic                    dir_v_r, dir_v_nxt;
  dir_rec_s                dir_rec_r, dir_rec_nxt;
  logic                    exec_v_r, exec_v_nxt;
  exec_s                   exec_r, exec_nxt;
  logic                    ovf_r, ovf_nxt;
  logic                    refused_r, refused_nxt;
  logic                    rec_r, rec_nxt;

  logic                    stk_push, stk_pop, stk_clear;
  logic                    stk_empty, stk_full;
  ret_s                    stk_top;
  logic                    fault_now, fault_event;

  call_return_stack u_stack (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_clear   (stk_clear),
    .i_push    (stk_push),
    .i_pop     (stk_pop),
    .i_data    (i_cmd.ret),
    .o_top     (stk_top),
    .o_empty   (stk_empty),
    .o_full    (stk_full)
  );

  fault_code_encoder u_fault (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_cause   (i_fault_cause),
    .o_rpt     (o_fault_rpt)
  );

  // launch on the rising edge of any fault or kill, not every cycle
  assign fault_now   = i_kill || (i_fault_cause != CAUSE_NONE);
  assign fault_event = fault_now && !fault_prev_r;

  ////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    state_nxt      = state_r;
    rec_num_nxt    = rec_num_r;
    defined_nxt    = defined_r;
    bytes_nxt      = bytes_r;
    dir_idx_nxt    = dir_idx_r;
    fsel_nxt       = fsel_r;
    fsel_v_nxt     = 1'b0;
    fault_prev_nxt = fault_now;
    dir_v_nxt      = 1'b0;
    dir_rec_nxt    = dir_rec_r;
    exec_v_nxt     = 1'b0;
    exec_nxt       = exec_r;
    ovf_nxt        = 1'b0;
    refused_nxt    = 1'b0;
    stk_push       = 1'b0;
    stk_pop        = 1'b0;
    stk_clear      = 1'b0;

    // directory walk: one slot per cycle, new commands are dropped
    if (state_r == ST_DIR) begin
      if (defined_r[dir_idx_r]) begin
        dir_v_nxt                = 1'b1;
        dir_rec_nxt.none_defined = 1'b0;
        dir_rec_nxt.seq          = dir_idx_r + `SEQ_MIN;
        dir_rec_nxt.bytes        = bytes_r[dir_idx_r];
        dir_rec_nxt.last         = !any_above(defined_r, dir_idx_r);
        if (dir_rec_nxt.last) begin
          state_nxt = ST_IDLE;
        end
      end
      if (dir_idx_r == `IDX_LAST) begin
        state_nxt = ST_IDLE;
      end
      dir_idx_nxt = dir_idx_r + `IDX_ONE;
    end

    if (i_cmd_valid && state_r == ST_REC && !i_cmd.immediate) begin
      if (i_cmd.op == OP_END_DEF) begin
        state_nxt              = ST_IDLE;
        defined_nxt[slot(rec_num_r)] = 1'b1;
      end else begin
        // buffered commands go into the sequence, not executed
        bytes_nxt[slot(rec_num_r)] = bytes_r[slot(rec_num_r)]
                                   + `BYTES_W'(i_cmd.len);
      end
    end else if (i_cmd_valid && state_r != ST_DIR) begin
      // while recording only immediate commands arrive here
      case (i_cmd.op)
        OP_DEFINE: begin
          if (state_r == ST_REC ||
              !in_range(i_cmd.num, `SEQ_MIN, `SEQ_MAX_DEF)) begin
            refused_nxt = 1'b1;
          end else if (defined_r[slot(i_cmd.num)]) begin
            refused_nxt = 1'b1;
          end else begin
            state_nxt                  = ST_REC;
            rec_num_nxt                = i_cmd.num;
            bytes_nxt[slot(i_cmd.num)] = `BYTES_ZERO;
          end
        end
        OP_ERASE: begin
          // the open recording cannot be erased under itself
          if (!in_range(i_cmd.num, `SEQ_MIN, `SEQ_MAX_DEF) ||
              (state_r == ST_REC && i_cmd.num == rec_num_r)) begin
            refused_nxt = 1'b1;
          end else begin
            defined_nxt[slot(i_cmd.num)] = 1'b0;
            bytes_nxt[slot(i_cmd.num)]   = `BYTES_ZERO;
          end
        end
        OP_DIR: begin
          if (defined_r == '0) begin
            dir_v_nxt   = 1'b1;
            dir_rec_nxt = '{none_defined: 1'b1, last: 1'b1,
                            seq: `SEQ_MIN - `SEQ_MIN,
                            bytes: `BYTES_ZERO};
          end else if (state_r == ST_IDLE) begin
            state_nxt   = ST_DIR;
            dir_idx_nxt = `IDX_ZERO;
          end else begin
            refused_nxt = 1'b1;
          end
        end
        OP_FSEL: begin
          if (in_range(i_cmd.num, `FSEL_MIN, `SEQ_MAX_RUN)) begin
            fsel_nxt   = i_cmd.num;
            fsel_v_nxt = 1'b1;
          end else begin
            refused_nxt = 1'b1;
          end
        end
        OP_JUMP: begin
          if (in_range(i_cmd.num, `SEQ_MIN, `SEQ_MAX_RUN)) begin
            exec_v_nxt = 1'b1;
            exec_nxt   = '{kind: EX_JUMP, seq: i_cmd.num,
                           ptr: '0};
          end else begin
            refused_nxt = 1'b1;
          end
        end
        OP_CALL: begin
          if (!in_range(i_cmd.num, `SEQ_MIN, `SEQ_MAX_RUN)) begin
            refused_nxt = 1'b1;
          end else if (stk_full) begin
            ovf_nxt = 1'b1;
          end else begin
            stk_push   = 1'b1;
            exec_v_nxt = 1'b1;
            exec_nxt   = '{kind: EX_CALL, seq: i_cmd.num, ptr: '0};
          end
        end
        default: begin
        end
      endcase
    end

    // a finished sequence returns to its caller if one is waiting and no other launch is made in that cycle
    if (i_seq_done && !stk_empty && !exec_v_nxt) begin
      stk_pop    = 1'b1;
      exec_v_nxt = 1'b1;
      exec_nxt   = '{kind: EX_RESUME, seq: stk_top.seq,
                     ptr: stk_top.ptr};
    end

    // fault wins over any other launch; pending returns are dropped
    if (fault_event && fsel_r != `FSEL_RESET) begin
      stk_clear  = 1'b1;
      stk_push   = 1'b0;
      stk_pop    = 1'b0;
      ovf_nxt    = 1'b0;
      exec_v_nxt = 1'b1;
      exec_nxt   = '{kind: EX_FAULT, seq: fsel_r, ptr: '0};
    end

    // recording flag kept in its own flop so the port is registered
    rec_nxt = (state_nxt == ST_REC);
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_r      <= ST_IDLE;
      rec_num_r    <= `SEQ_MIN;
      defined_r    <= '0;
      dir_idx_r    <= `IDX_ZERO;
      fsel_r       <= `FSEL_RESET;
      fsel_v_r     <= 1'b0;
      fault_prev_r <= 1'b0;
      dir_v_r      <= 1'b0;
      dir_rec_r    <= '0;
      exec_v_r     <= 1'b0;
      exec_r       <= '0;
      ovf_r        <= 1'b0;
      refused_r    <= 1'b0;
      rec_r        <= 1'b0;
      for (int i = 0; i < `SEQ_COUNT; i++) begin
        bytes_r[i] <= `BYTES_ZERO;
      end
    end else if (i_ce) begin
      state_r      <= state_nxt;
      rec_num_r    <= rec_num_nxt;
      defined_r    <= defined_nxt;
      dir_idx_r    <= dir_idx_nxt;
      fsel_r       <= fsel_nxt;
      fsel_v_r     <= fsel_v_nxt;
      fault_prev_r <= fault_prev_nxt;
      dir_v_r      <= dir_v_nxt;
      dir_rec_r    <= dir_rec_nxt;
      exec_v_r     <= exec_v_nxt;
      exec_r       <= exec_nxt;
      ovf_r        <= ovf_nxt;
      refused_r    <= refused_nxt;
      rec_r        <= rec_nxt;
      bytes_r      <= bytes_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all registered

  assign o_recording     = rec_r;
  assign o_rec_seq       = rec_num_r;
  assign o_dir_valid     = dir_v_r;
  assign o_dir_rec       = dir_rec_r;
  assign o_fsel_valid    = fsel_v_r;
  assign o_fsel          = fsel_r;
  assign o_exec_valid    = exec_v_r;
  assign o_exec          = exec_r;
  assign o_call_overflow = ovf_r;
  assign o_cmd_refused   = refused_r;
endmodule

// *** bench/sequence_store_checker.sv ***
// port assertions for the sequence store controller
`timescale 1ns/10ps
module sequence_store_checker
  import seq_pkg::*;
(
  input wire logic         i_clk,
  input wire logic         i_sys_rst,
  input wire logic         i_ce,
  input wire logic         i_cmd_valid,
  input wire cmd_s         i_cmd,
  input wire logic         i_kill,
  input wire fault_cause_e i_fault_cause,
  input wire logic         o_recording,
  input wire logic [5:0]   o_rec_seq,
  input wire logic         o_dir_valid,
  input wire dir_rec_s     o_dir_rec,
  input wire logic         o_fsel_valid,
  input wire logic [5:0]   o_fsel,
  input wire logic         o_exec_valid,
  input wire exec_s        o_exec,
  input wire logic         o_call_overflow,
  input wire logic         o_cmd_refused,
  input wire fault_rpt_s   o_fault_rpt
);
  logic walk_r, walk_nxt, flt_r, flt_nxt, tk, ex, rise;
  ////////////////////////////////////////////////////////////////////
  // commands are dropped while a directory walk runs
  always_comb begin
    tk = i_ce && i_cmd_valid && !walk_r;
    ex = tk && (i_cmd.immediate || !o_recording);
    flt_nxt = i_ce ? (i_kill || i_fault_cause != CAUSE_NONE) : flt_r;
    rise = i_ce && flt_nxt && !flt_r;
    walk_nxt = walk_r;
    if (ex && i_cmd.op == OP_DIR) walk_nxt = 1'b1;
    else if ((o_dir_valid && o_dir_rec.last) || o_cmd_refused)
      walk_nxt = 1'b0;
  end
  always_ff @(posedge i_clk) begin
    walk_r <= i_sys_rst ? 1'b0 : walk_nxt;
    flt_r  <= i_sys_rst ? 1'b0 : flt_nxt;
  end
  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  AST_DEF_RANGE: assert property (
    ex && i_cmd.op == OP_DEFINE && (i_cmd.num == 6'h00 || i_cmd.num > 6'h28)
    |=> o_cmd_refused && $stable(o_rec_seq)) else $error("bad define kept");
  AST_DEF_OPEN: assert property (
    tk && i_cmd.op == OP_DEFINE && !o_recording && i_cmd.num != 6'h00
    && i_cmd.num <= 6'h28 |=> o_cmd_refused
    || (o_recording && o_rec_seq == $past(i_cmd.num)))
    else $error("define did not open");
  AST_DEF_HOLD: assert property (
    o_recording && !(tk && i_cmd.op == OP_END_DEF) |=> o_recording)
    else $error("recording closed early");
  AST_JUMP: assert property (
    ex && i_cmd.op == OP_JUMP && i_cmd.num != 6'h00 && i_cmd.num <= 6'h27
    && !rise |=> o_exec_valid && o_exec.kind == EX_JUMP
    && o_exec.seq == $past(i_cmd.num)) else $error("jump not started");
  AST_CALL: assert property (
    ex && i_cmd.op == OP_CALL && i_cmd.num != 6'h00 && i_cmd.num <= 6'h27
    && !rise |=> (o_exec_valid && o_exec.kind == EX_CALL) != o_call_overflow)
    else $error("call neither started nor refused");
  AST_FSEL: assert property (
    ex && i_cmd.op == OP_FSEL && i_cmd.num <= 6'h27
    |=> o_fsel_valid && o_fsel == $past(i_cmd.num))
    else $error("fault selection not taken");
  AST_FSEL_RANGE: assert property (
    ex && i_cmd.op == OP_FSEL && i_cmd.num > 6'h27
    |=> o_cmd_refused && $stable(o_fsel)) else $error("bad selection kept");
  AST_FAULT: assert property (
    rise && o_fsel != 6'h00 |=> o_exec_valid && o_exec.kind == EX_FAULT
    && o_exec.seq == $past(o_fsel)) else $error("fault sequence not run");
  AST_NO_FAULT: assert property (
    rise && o_fsel == 6'h00 |=> !(o_exec_valid && o_exec.kind == EX_FAULT))
    else $error("fault run with zero selection");
  AST_CURR: assert property (
    i_ce && i_fault_cause == CAUSE_CURR |=> o_fault_rpt.code == 8'h22)
    else $error("current fault code wrong");
  AST_PANEL: assert property (
    o_fault_rpt.panel == (o_fault_rpt.code != 8'h60))
    else $error("panel flag wrong");
endmodule

// *** bench/host_cmd_model.sv ***
// host side model: issues text-level commands as single transfers
`timescale 1ns/10ps
module host_cmd_model
  import seq_pkg::*;
(
  input  wire logic i_clk,
  output logic      o_cmd_valid,
  output cmd_s      o_cmd
);
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd       = '0;
  end
  // held across exactly one rising edge, then released
  task automatic send(input cmd_op_e op, input logic [5:0] num,
                      input logic imm, input logic [7:0] len,
                      input ret_s ret);
    @(negedge i_clk);
    o_cmd_valid = 1'b1;
    o_cmd       = '{op, num, imm, len, ret};
    @(negedge i_clk);
    o_cmd_valid = 1'b0;
    // idle fields carry junk so a stale command is never trusted
    o_cmd       = ~o_cmd;
  endtask
endmodule

// *** bench/tb_sequence_store_ctrl.sv ***
// self-checking bench for the sequence store controller
`timescale 1ns/10ps
module tb_sequence_store_ctrl
  import seq_pkg::*;
;
  logic clk = 0, sys_rst = 1, ce = 1, seq_done = 0, kill = 0;
  fault_cause_e cause = CAUSE_NONE;
  logic cmd_valid, recording, dir_valid, fsel_valid, exec_valid;
  logic call_ovf, refused;
  logic [5:0] rec_seq, fsel;
  cmd_s cmd;
  dir_rec_s dir_rec;
  exec_s ex;
  fault_rpt_s rpt;
  int bad_count = 0;
  int checks_done = 0;
  always #10 clk = ~clk;
  host_cmd_model u_host_cmd_model (.i_clk(clk), .o_cmd_valid(cmd_valid),
    .o_cmd(cmd));
  sequence_store_ctrl u_sequence_store_ctrl (.i_clk(clk),
    .i_sys_rst(sys_rst), .i_ce(ce), .i_cmd_valid(cmd_valid), .i_cmd(cmd),
    .i_seq_done(seq_done), .i_kill(kill), .i_fault_cause(cause),
    .o_recording(recording), .o_rec_seq(rec_seq), .o_dir_valid(dir_valid),
    .o_dir_rec(dir_rec), .o_fsel_valid(fsel_valid), .o_fsel(fsel),
    .o_exec_valid(exec_valid), .o_exec(ex), .o_call_overflow(call_ovf),
    .o_cmd_refused(refused), .o_fault_rpt(rpt));
  ////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic c(input cmd_op_e op, input logic [5:0] num,
                   input logic imm = 1'b0, input logic [7:0] len = 8'h00);
    u_host_cmd_model.send(op, num, imm, len, '0);
  endtask
  task automatic rec(input logic [5:0] s, input logic [15:0] b,
                     input logic last);
    int n;
    n = 0;
    while (dir_valid !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    chk("dir_valid", 16'h0001, {15'h0000, dir_valid});
    if (n == 50) wrap_up();
    chk("dir seq", {10'h000, s}, {10'h000, dir_rec.seq});
    chk("dir bytes", b, dir_rec.bytes);
    chk("dir last", {15'h0000, last}, {15'h0000, dir_rec.last});
    @(negedge clk);
  endtask
  task automatic done();
    @(negedge clk);
    seq_done = 1;
    @(negedge clk);
    seq_done = 0;
  endtask
  task automatic to_cause(input fault_cause_e f, input logic [7:0] code);
    @(negedge clk);
    cause = f;
    @(negedge clk);
    chk("fault code", {8'h00, code}, {8'h00, rpt.code});
    chk("panel", {15'h0000, code != 8'h60}, {15'h0000, rpt.panel});
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic s_store();
    chk("reset state", 16'h0001,
        {recording, fsel, rpt.code, rpt.panel});
    chk("rec_seq", 16'h0001, {10'h000, rec_seq});
    c(OP_DIR, 6'h00);
    chk("none_defined", 16'h0001, {15'h0000, dir_rec.none_defined});
    rec(6'h00, 16'h0000, 1'b1);
    c(OP_ERASE, 6'h05);
    c(OP_DEFINE, 6'h05);
    chk("rec_seq", 16'h0045, {9'h000, recording, rec_seq});
    c(OP_OTHER, 6'h00, 1'b0, 8'h03);
    c(OP_FSEL, 6'h09, 1'b1);
    chk("fsel", 16'h0049, {9'h000, fsel_valid, fsel});
    c(OP_OTHER, 6'h00, 1'b1, 8'h07);
    c(OP_END_DEF, 6'h00);
    chk("recording", 16'h0000, {15'h0000, recording});
    c(OP_DEFINE, 6'h05);
    chk("redefine refused", 16'h0001, {15'h0000, refused});
    c(OP_DEFINE, 6'h28);
    c(OP_OTHER, 6'h00, 1'b0, 8'hFF);
    c(OP_OTHER, 6'h00, 1'b0, 8'h02);
    c(OP_END_DEF, 6'h00);
    c(OP_DEFINE, 6'h09);
    c(OP_END_DEF, 6'h00);
    c(OP_DEFINE, 6'h29);
    chk("define 41", 16'h0001, {15'h0000, refused});
    c(OP_DIR, 6'h00);
    rec(6'h05, 16'h0003, 1'b0);
    rec(6'h09, 16'h0000, 1'b0);
    rec(6'h28, 16'h0101, 1'b1);
    c(OP_ERASE, 6'h05);
    c(OP_ERASE, 6'h29);
    chk("erase 41", 16'h0001, {15'h0000, refused});
    c(OP_DIR, 6'h00);
    rec(6'h09, 16'h0000, 1'b0);
    rec(6'h28, 16'h0101, 1'b1);
  endtask
  task automatic s_exec();
    c(OP_JUMP, 6'h27);
    chk("jump", {8'h01, EX_JUMP, 6'h27}, {7'h00, exec_valid, ex.kind,
        ex.seq});
    c(OP_JUMP, 6'h28);
    chk("jump 40", 16'h0001, {14'h0000, exec_valid, refused});
    c(OP_JUMP, 6'h07);
    done();
    chk("no return", 16'h0000, {15'h0000, exec_valid});
    for (int i = 0; i < 17; i++) begin
      u_host_cmd_model.send(OP_CALL, 6'h03, 1'b0, 8'h00, '{6'h01, 16'(i)});
      chk("call", (i < 16) ? 16'h0002 : 16'h0001,
          {14'h0000, exec_valid, call_ovf});
    end
    for (int i = 15; i >= 0; i--) begin
      done();
      chk("resume", {8'h01, EX_RESUME, 6'h01}, {7'h00, exec_valid, ex.kind,
          ex.seq});
      chk("resume ptr", 16'(i), ex.ptr);
    end
  endtask
  task automatic s_fault();
    c(OP_FSEL, 6'h28);
    chk("fsel 40", 16'h0001, {15'h0000, refused});
    c(OP_FSEL, 6'h00);
    @(negedge clk);
    kill = 1;
    @(negedge clk);
    chk("no fault run", 16'h0000, {15'h0000, exec_valid});
    kill = 0;
    c(OP_FSEL, 6'h09);
    to_cause(CAUSE_CURR, 8'h22);
    chk("fault run", {8'h01, EX_FAULT, 6'h09}, {7'h00, exec_valid, ex.kind,
        ex.seq});
    to_cause(CAUSE_DOFF, 8'h16);
    to_cause(CAUSE_PLUG, 8'h23);
    to_cause(CAUSE_USER, 8'h66);
    to_cause(CAUSE_CPU, 8'h88);
    to_cause(CAUSE_SER, 8'h60);
    to_cause(CAUSE_NONE, 8'h00);
    // frozen clock enable must swallow a command whole
    ce = 0;
    c(OP_FSEL, 6'h04);
    chk("frozen fsel", 16'h0009, {9'h000, fsel_valid, fsel});
    ce = 1;
  endtask
  initial begin
    repeat (3) @(negedge clk);
    sys_rst = 0;
    s_store();
    s_exec();
    s_fault();
    wrap_up();
  end
endmodule
bind sequence_store_ctrl sequence_store_checker u_chk (.i_clk(i_clk),
  .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_cmd_valid(i_cmd_valid),
  .i_cmd(i_cmd), .i_kill(i_kill), .i_fault_cause(i_fault_cause),
  .o_recording(o_recording), .o_rec_seq(o_rec_seq),
  .o_dir_valid(o_dir_valid), .o_dir_rec(o_dir_rec),
  .o_fsel_valid(o_fsel_valid), .o_fsel(o_fsel),
  .o_exec_valid(o_exec_valid), .o_exec(o_exec),
  .o_call_overflow(o_call_overflow), .o_cmd_refused(o_cmd_refused),
  .o_fault_rpt(o_fault_rpt));
